// ==== hw/ccpu_defs.vh ====
// constants for the capture/compare/pwm unit: offsets, fields, reset values
`ifndef CCPU_DEFS_VH
`define CCPU_DEFS_VH

// register byte offsets on the apb slave
`define CCPU_OFS_CONTROL     12'h000
`define CCPU_OFS_DATA_LOW    12'h004
`define CCPU_OFS_DATA_HIGH   12'h008
`define CCPU_OFS_STATUS      12'h00c

// unit_control fields
`define CCPU_MODE_MSB        3
`define CCPU_MODE_LSB        0
`define CCPU_DUTY_MSB        5
`define CCPU_DUTY_LSB        4
`define CCPU_CONTROL_MASK    8'h3f

// unit_status fields
`define CCPU_STAT_FLAG       0
`define CCPU_STAT_T3         1
`define CCPU_STAT_T4         2

// reset values
`define CCPU_RST_CONTROL     8'h00
`define CCPU_RST_DATA        8'h00

// unit_mode_field encodings
`define CCPU_M_OFF           4'h0
`define CCPU_M_TOGGLE        4'h2
`define CCPU_M_CAP_FALL      4'h4
`define CCPU_M_CAP_RISE      4'h5
`define CCPU_M_CAP_RISE4     4'h6
`define CCPU_M_CAP_RISE16    4'h7
`define CCPU_M_SET_HIGH      4'h8
`define CCPU_M_SET_LOW       4'h9
`define CCPU_M_SOFT_INT      4'ha
`define CCPU_M_SPECIAL       4'hb

// timer_assign_bits encodings
`define CCPU_TA_ALL_FIRST    2'h0
`define CCPU_TA_ONE_ONLY     2'h1
`define CCPU_TA_ONE_TWO      2'h2
`define CCPU_TA_ALL_THIRD    2'h3

// capture prescale terminal counts
`define CCPU_PRE4_LAST       2'h3
`define CCPU_PRE16_LAST      4'hf

`endif

// ==== hw/ccpu_unit.v ====
// one capture/compare/pwm unit with its apb register slave
//
// Behaviour
// - mode 0000 disables the unit; data bytes and flag keep their values
// - modes 0100..0111 capture on fall, rise, 4th rise, 16th rise
// - mode 0010 toggles output on each match and sets the flag
// - mode 1000 drives pin low on entry, high on match, sets flag
// - mode 1001 drives pin high on entry, low on match, sets flag
// - mode 1010 only sets the flag on match, pin untouched
// - units one, two: 1011 sets flag and resets the assigned 16-bit timer
// - units three to five: 1011 acts like 1010
// - modes 11xx are pwm; duty = low data byte and control bits 5:4
// - 16-bit data register as two read/write bytes beside control
// - capture/compare use timer one or three, pwm timer two or four
// - timer choice comes from the two timer assign bits, shared per kind
// - one setting gives timers one and two to unit one only
// - another gives timers one and two to units one and two only
// - capture event copies the full selected 16-bit timer into data
// - each capture sets the flag; only software clears it
// - a new capture overwrites the old value with no overrun mark
// - with pin as output, a port write changing it is a capture event
// - mode changes may set a spurious flag; software masks and clears it
// - prescaler counter cleared when unit is off or not capturing
// - switching capture prescale keeps the counter; first capture may be early
// - unit two special event also starts a conversion if converter enabled
// - writing zero to control forces the output latch low
`include "ccpu_defs.vh"

module ccpu_unit #(
  parameter [2:0] UNIT_NUMBER = 3'd1
) (
  input  wire        i_mclk,
  input  wire        i_sys_rst,
  // apb slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire        o_pready,
  output wire        o_pslverr,
  // timer side
  input  wire [1:0]  i_timer_assign,
  input  wire [15:0] i_first_timer_count,
  input  wire [15:0] i_third_timer_count,
  input  wire        i_adc_enabled,
  // pin side
  input  wire        i_unit_pin,
  input  wire        i_pin_is_output,
  input  wire        i_port_data,
  output wire        o_compare_out,
  output wire        o_unit_event_flag,
  output wire        o_reset_first_timer,
  output wire        o_reset_third_timer,
  output wire        o_start_conversion,
  output wire        o_use_third_timer,
  output wire        o_use_fourth_timer,
  output wire        o_pwm_active,
  output wire [9:0]  o_pwm_duty
);

  // capture prescale state machine, one-hot
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_CAPT = 2'b10;
  // idle pins the count at zero, so every entry into capture starts clean

  // unit uses the third/fourth timer pair under the given assign bits
  function use_upper_pair;
    input [1:0] assign_bits;
    input [2:0] unit;
    begin
      case (assign_bits)
        `CCPU_TA_ALL_FIRST: use_upper_pair = 1'b0;
        `CCPU_TA_ONE_ONLY:  use_upper_pair = (unit != 3'd1);
        `CCPU_TA_ONE_TWO:   use_upper_pair = (unit > 3'd2);
        `CCPU_TA_ALL_THIRD: use_upper_pair = 1'b1;
        default:            use_upper_pair = 1'b0;
      endcase
    end
  endfunction

  // register decode, used by the read path only; write strobes compare the address directly
  function [1:0] reg_index;
    input [11:0] addr;
    begin
      case (addr)
        `CCPU_OFS_CONTROL:   reg_index = 2'd0;
        `CCPU_OFS_DATA_LOW:  reg_index = 2'd1;
        `CCPU_OFS_DATA_HIGH: reg_index = 2'd2;
        default:             reg_index = 2'd3;
      endcase
    end
  endfunction

  function reg_mapped;
    input [11:0] addr;
    begin
      reg_mapped = (addr == `CCPU_OFS_CONTROL) || (addr == `CCPU_OFS_DATA_LOW) ||
                   (addr == `CCPU_OFS_DATA_HIGH) || (addr == `CCPU_OFS_STATUS);
    end
  endfunction

  // software registers, pin history and the output flops
  reg  [7:0]  control_q;
  reg  [7:0]  data_low_q;
  reg  [7:0]  data_high_q;
  reg         flag_q;
  reg  [31:0] prdata_q;
  reg         pready_q;
  reg         pslverr_q;
  reg         pin_meta_q;
  reg         pin_sync_q;
  reg         level_prev_q;
  reg  [3:0]  presc_q;
  reg  [1:0]  state_q;
  reg         out_q;
  reg         match_prev_q;
  reg         rst_first_q;
  reg         rst_third_q;
  reg         start_conv_q;
  reg         use_t3_q;
  reg         use_t4_q;
  reg         pwm_q;
  reg  [9:0]  duty_q;

  // decoded mode, bus strobes and event nets
  wire [3:0]  mode;
  wire        wr_access;
  wire        wr_control;
  wire        wr_data_low;
  wire        wr_data_high;
  wire        wr_status;
  wire        is_capture;
  wire        is_compare;
  wire        upper_pair;
  wire [15:0] sel_timer;
  wire [15:0] data_word;
  wire        level_now;
  wire        rise;
  wire        fall;
  wire        cap_event;
  wire        match_now;
  wire        match_edge;
  wire        special_ok;
  wire        cmp_flag;

  assign mode       = control_q[`CCPU_MODE_MSB:`CCPU_MODE_LSB];
  assign data_word  = {data_high_q, data_low_q};
  assign upper_pair = use_upper_pair(i_timer_assign, UNIT_NUMBER);
  // capture/compare reads a 16-bit timer only, pwm never does
  assign sel_timer  = upper_pair ? i_third_timer_count
                                 : i_first_timer_count;
  assign is_capture = (mode[3:2] == 2'b01);
  assign is_compare = (mode == `CCPU_M_TOGGLE) || (mode[3:2] == 2'b10);

  // apb write strobes, taken in the access phase only
  assign wr_access    = i_psel & i_penable & i_pwrite;
  assign wr_control   = wr_access & (i_paddr == `CCPU_OFS_CONTROL);
  assign wr_data_low  = wr_access & (i_paddr == `CCPU_OFS_DATA_LOW);
  assign wr_data_high = wr_access & (i_paddr == `CCPU_OFS_DATA_HIGH);
  assign wr_status    = wr_access & (i_paddr == `CCPU_OFS_STATUS);

  // pin synchroniser; the first stage feeds only the second
  // two stages, since the pin may change at any point of the clock period
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= i_unit_pin;
      pin_sync_q <= pin_meta_q;
    end
  end

  // an output pin is read back from the port latch, so port writes become edges
  // the port latch is already on this clock, so it skips the synchroniser
  assign level_now = i_pin_is_output ? i_port_data : pin_sync_q;
  assign rise      = level_now & ~level_prev_q;
  assign fall      = ~level_now & level_prev_q;

  // event selection by mode and prescale count
  assign cap_event = (state_q == ST_CAPT) &&
                     (((mode == `CCPU_M_CAP_FALL) && fall) ||
                      ((mode == `CCPU_M_CAP_RISE) && rise) ||
                      ((mode == `CCPU_M_CAP_RISE4) && rise &&
                       (presc_q[1:0] == `CCPU_PRE4_LAST)) ||
                      ((mode == `CCPU_M_CAP_RISE16) && rise &&
                       (presc_q == `CCPU_PRE16_LAST)));

  // match fires once as the timer reaches the data word
  // edge only: a timer parked on the data word must not keep setting the flag
  assign match_now  = is_compare && (sel_timer == data_word);
  assign match_edge = match_now & ~match_prev_q;
  assign special_ok = (UNIT_NUMBER == 3'd1) || (UNIT_NUMBER == 3'd2);
  // every compare mode sets the flag on a match
  assign cmp_flag   = match_edge;

  // edge history and match history
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      level_prev_q <= 1'b0;
      match_prev_q <= 1'b0;
    end else begin
      level_prev_q <= level_now;
      match_prev_q <= match_now;
    end
  end

  // prescale state: leaving capture modes clears the count
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
      presc_q <= 4'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          presc_q <= 4'h0;
          if (is_capture) begin
            state_q <= ST_CAPT;
          end
        end
        ST_CAPT: begin
          if (!is_capture) begin
            state_q <= ST_IDLE;
            presc_q <= 4'h0;
          end else if (rise) begin
            // kept across prescale changes, so the next capture may come early
            presc_q <= presc_q + 4'h1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          presc_q <= 4'h0;
        end
      endcase
    end
  end

  // control register; bits 7:6 read zero
  // writing mode 0000 also clears the prescaler and the output latch elsewhere
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      control_q <= `CCPU_RST_CONTROL;
    end else if (wr_control) begin
      control_q <= i_pwdata[7:0] & `CCPU_CONTROL_MASK;
    end
  end

  // data register: capture wins over a same-cycle software write
  // limitation: a capture between two byte reads mixes old and new halves
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      data_low_q  <= `CCPU_RST_DATA;
      data_high_q <= `CCPU_RST_DATA;
    end else if (cap_event) begin
      // no overrun mark: an unread capture is simply replaced
      data_low_q  <= sel_timer[7:0];
      data_high_q <= sel_timer[15:8];
    end else begin
      if (wr_data_low) begin
        data_low_q <= i_pwdata[7:0];
      end
      if (wr_data_high) begin
        data_high_q <= i_pwdata[7:0];
      end
    end
  end

  // event flag: hardware only sets, write one clears, set wins
  // a mode change may leave a stale flag; clearing it is left to software
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      flag_q <= 1'b0;
    end else if (cap_event || cmp_flag) begin
      flag_q <= 1'b1;
    end else if (wr_status && i_pwdata[`CCPU_STAT_FLAG]) begin
      flag_q <= 1'b0;
    end
  end

  // compare output latch: entry values on control write, actions on match
  // entry level follows the newly written mode, so 1000/1001 start at once
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      out_q <= 1'b0;
    end else if (wr_control) begin
      case (i_pwdata[`CCPU_MODE_MSB:`CCPU_MODE_LSB])
        `CCPU_M_OFF:      out_q <= 1'b0;
        `CCPU_M_SET_HIGH: out_q <= 1'b0;
        `CCPU_M_SET_LOW:  out_q <= 1'b1;
        default:          out_q <= out_q;
      endcase
    end else if (match_edge) begin
      case (mode)
        `CCPU_M_TOGGLE:   out_q <= ~out_q;
        `CCPU_M_SET_HIGH: out_q <= 1'b1;
        `CCPU_M_SET_LOW:  out_q <= 1'b0;
        default:          out_q <= out_q;
      endcase
    end
  end

  // special event pulses; units three to five never raise them
  // registered, so each pulse lasts exactly one cycle
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rst_first_q  <= 1'b0;
      rst_third_q  <= 1'b0;
      start_conv_q <= 1'b0;
    end else begin
      rst_first_q  <= special_ok && (mode == `CCPU_M_SPECIAL) && match_edge &&
                      !upper_pair;
      rst_third_q  <= special_ok && (mode == `CCPU_M_SPECIAL) && match_edge &&
                      upper_pair;
      start_conv_q <= (UNIT_NUMBER == 3'd2) && (mode == `CCPU_M_SPECIAL) &&
                      match_edge && i_adc_enabled;
    end
  end

  // timer routing and pwm duty, registered for the outputs
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      use_t3_q <= 1'b0;
      use_t4_q <= 1'b0;
      pwm_q    <= 1'b0;
      duty_q   <= 10'h000;
    end else begin
      use_t3_q <= upper_pair && (is_capture || is_compare);
      use_t4_q <= upper_pair && (mode[3:2] == 2'b11);
      pwm_q    <= (mode[3:2] == 2'b11);
      duty_q   <= {data_low_q, control_q[`CCPU_DUTY_MSB:`CCPU_DUTY_LSB]};
    end
  end

  // apb answer: read data latched in the setup cycle, zero wait states
  // pready drops only in reset; a read returns the value seen at setup
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= 1'b1;
      if (i_psel && !i_penable) begin
        pslverr_q <= !reg_mapped(i_paddr);
        case (reg_index(i_paddr))
          2'd0:    prdata_q <= {24'h000000, control_q};
          2'd1:    prdata_q <= {24'h000000, data_low_q};
          2'd2:    prdata_q <= {24'h000000, data_high_q};
          default: prdata_q <= (i_paddr == `CCPU_OFS_STATUS) ?
                               {29'h00000000, use_t4_q, use_t3_q, flag_q} :
                               32'h0000_0000;
        endcase
      end
    end
  end

  // every output comes straight from a flip-flop
  assign o_prdata            = prdata_q;
  assign o_pready            = pready_q;
  assign o_pslverr           = pslverr_q;
  assign o_compare_out       = out_q;
  assign o_unit_event_flag   = flag_q;
  assign o_reset_first_timer = rst_first_q;
  assign o_reset_third_timer = rst_third_q;
  assign o_start_conversion  = start_conv_q;
  assign o_use_third_timer   = use_t3_q;
  assign o_use_fourth_timer  = use_t4_q;
  assign o_pwm_active        = pwm_q;
  assign o_pwm_duty          = duty_q;

endmodule

// ==== test/ccpu_sva.sv ====
// port assertions for the capture/compare/pwm unit, bound to every unit
module ccpu_sva #(
  parameter [2:0] UNIT_NUMBER = 3'd1
) (
  input wire        i_mclk,
  input wire        i_sys_rst,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire        o_pslverr,
  input wire        o_compare_out,
  input wire        o_unit_event_flag,
  input wire        o_reset_first_timer,
  input wire        o_start_conversion,
  input wire        o_use_third_timer,
  input wire        o_pwm_active,
  input wire [9:0]  o_pwm_duty
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // access phase qualifiers
  wire acc    = i_psel && i_penable;
  wire ctl_wr = acc && i_pwrite && i_paddr == 12'h000;
  wire clr_wr = acc && i_pwrite && i_paddr == 12'h00c && i_pwdata[0];
  sequence s_pwm_wr;
    ctl_wr && i_pwdata[3:2] == 2'h3;
  endsequence
  sequence s_off_wr;
    ctl_wr && i_pwdata[3:0] == 4'h0;
  endsequence
  AST_CTL_UPPER_ZERO: assert property (
    acc && !i_pwrite && i_paddr == 12'h000 |-> o_prdata[31:6] == 26'h0)
    else $error("control upper bits not zero");
  AST_SLVERR_MAP: assert property (
    acc |-> o_pslverr == (i_paddr > 12'h00c || i_paddr[1:0] != 2'h0))
    else $error("slave error wrong for address");
  AST_PWM_ENTRY: assert property (
    ctl_wr |-> ##2 o_pwm_active == ($past(i_pwdata[3:2], 2) == 2'h3))
    else $error("pwm active does not follow mode");
  AST_PWM_DUTY: assert property (
    s_pwm_wr |-> ##2 o_pwm_duty[1:0] == $past(i_pwdata[5:4], 2))
    else $error("duty low bits wrong");
  AST_OFF_OUT_LOW: assert property (
    s_off_wr |-> ##2 !o_compare_out)
    else $error("output latch not low after off");
  AST_SPECIAL_ONE: assert property (
    $rose(o_reset_first_timer) |=> !o_reset_first_timer)
    else $error("timer reset pulse too long");
  AST_SPECIAL_FLAG: assert property (
    o_reset_first_timer |-> o_unit_event_flag)
    else $error("special event without flag");
  AST_SPECIAL_TIMER: assert property (
    o_reset_first_timer |-> !o_use_third_timer)
    else $error("first timer reset while third selected");
  AST_NO_CONV: assert property (
    UNIT_NUMBER != 3'd2 |-> !o_start_conversion)
    else $error("conversion start from wrong unit");
  AST_FLAG_STICKY: assert property (
    o_unit_event_flag && !clr_wr |=> o_unit_event_flag)
    else $error("flag cleared by hardware");
endmodule

bind ccpu_unit ccpu_sva #(.UNIT_NUMBER(UNIT_NUMBER)) u_sva (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pslverr(o_pslverr), .o_compare_out(o_compare_out),
  .o_unit_event_flag(o_unit_event_flag), .o_reset_first_timer(o_reset_first_timer),
  .o_start_conversion(o_start_conversion), .o_use_third_timer(o_use_third_timer),
  .o_pwm_active(o_pwm_active), .o_pwm_duty(o_pwm_duty));

// ==== test/ccpu_pin_model.sv ====
// partner model: capture pin driver and the two 16-bit timer counts
module ccpu_pin_model (
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_pin_req,
  input  wire logic        i_load,
  input  wire logic [15:0] i_load_val,
  input  wire logic        i_clear_first,
  output logic             o_unit_pin,
  output logic [15:0]      o_first_count,
  output logic [15:0]      o_third_count
);
  timeunit 1ns;
  timeprecision 1ns;
  // timers only move on this clock, never as an async counter
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_unit_pin    <= 1'b0;
      o_first_count <= 16'h0000;
      o_third_count <= 16'h0000;
    end else begin
      o_unit_pin <= i_pin_req; // pin kept an input level
      if (i_clear_first)
        o_first_count <= 16'h0000; // special event resets timer
      else if (i_load)
        o_first_count <= i_load_val;
      if (i_load)
        o_third_count <= i_load_val ^ 16'hffff; // differs so selection shows
    end
  end
endmodule

// ==== test/test_capture_compare_pwm_unit.sv ====
// self-checking bench for the capture/compare/pwm unit
module test_capture_compare_pwm_unit;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, psel, pen, pwr, preq, ld, aen, pio, pdat, pin, pr, er;
  logic        cmp, flg, rf, rt, sc, u3, u4, pwm, c3, f3, rf3, rt3, sc3, u33;
  logic [11:0] pa;
  logic [31:0] pwd, prd, r, lf, e_ctl, e_lo, e_hi, e_fl;
  logic [15:0] t1, t3, lv, v, x;
  logic [9:0]  duty;
  logic [1:0]  ta;
  logic [3:0]  cm [6] = '{4'h2, 4'h8, 4'h9, 4'ha, 4'hb, 4'hb};
  integer      mismatches, tests_run, m, n, k;
  ccpu_pin_model i_pm (.i_mclk(clk), .i_sys_rst(rst), .i_pin_req(preq), .i_load(ld),
    .i_load_val(lv), .i_clear_first(rf), .o_unit_pin(pin), .o_first_count(t1),
    .o_third_count(t3));
  ccpu_unit #(.UNIT_NUMBER(3'd2)) i_dut (.i_mclk(clk), .i_sys_rst(rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(pr),
    .o_pslverr(er), .i_timer_assign(ta), .i_first_timer_count(t1),
    .i_third_timer_count(t3), .i_adc_enabled(aen), .i_unit_pin(pin),
    .i_pin_is_output(pio), .i_port_data(pdat), .o_compare_out(cmp),
    .o_unit_event_flag(flg), .o_reset_first_timer(rf), .o_reset_third_timer(rt),
    .o_start_conversion(sc), .o_use_third_timer(u3), .o_use_fourth_timer(u4),
    .o_pwm_active(pwm), .o_pwm_duty(duty));
  // a unit without special event, fed the same bus, pin and timers
  ccpu_unit #(.UNIT_NUMBER(3'd3)) i_dut_far (.i_mclk(clk), .i_sys_rst(rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(),
    .o_pready(), .o_pslverr(), .i_timer_assign(ta), .i_first_timer_count(t1),
    .i_third_timer_count(t3), .i_adc_enabled(aen), .i_unit_pin(pin),
    .i_pin_is_output(pio), .i_port_data(pdat), .o_compare_out(c3),
    .o_unit_event_flag(f3), .o_reset_first_timer(rf3), .o_reset_third_timer(rt3),
    .o_start_conversion(sc3), .o_use_third_timer(u33), .o_use_fourth_timer(),
    .o_pwm_active(), .o_pwm_duty());
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  function [31:0] nx(input [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input string nm, input [31:0] s, input [31:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task apb(input w, input [11:0] a, input [31:0] d);
    psel <= 1; pwr <= w; pa <= a; pwd <= d; pen <= 0;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (pr !== 1'b1) @(posedge clk);
    r = prd;
    psel <= 0; pen <= 0;
    @(posedge clk);
  endtask
  task rd(input string nm, input [11:0] a, input [31:0] e);
    apb(0, a, 32'h0);
    chk(nm, r, e);
  endtask
  // write plus reference-model update
  task wr(input [11:0] a, input [31:0] d);
    apb(1, a, d);
    case (a)
      12'h000: e_ctl = d & 32'h3f;
      12'h004: e_lo = d & 32'hff;
      12'h008: e_hi = d & 32'hff;
      default: if (d[0]) e_fl = 0;
    endcase
  endtask
  task regs;
    rd("control", 12'h000, e_ctl);
    rd("data_low", 12'h004, e_lo);
    rd("data_high", 12'h008, e_hi);
    apb(0, 12'h00c, 32'h0);
    chk("flag", r[0], e_fl[0]);
  endtask
  task ld_t(input [15:0] val);
    lv <= val; ld <= 1;
    @(posedge clk);
    ld <= 0;
  endtask
  task pulse;
    preq <= 1;
    repeat (5) @(posedge clk);
    preq <= 0;
    repeat (5) @(posedge clk);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    print_verdict;
  end
  initial begin
    rst = 1; psel = 0; pen = 0; pwr = 0; pa = 0; pwd = 0; preq = 0; ld = 0; lv = 0;
    aen = 1; pio = 0; pdat = 0; ta = 0; lf = 32'd72899;
    mismatches = 0; tests_run = 0; e_ctl = 0; e_lo = 0; e_hi = 0; e_fl = 0;
    repeat (6) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    regs;
    apb(0, 12'h010, 32'h0);
    chk("unmapped_rd", r, 0);
    chk("unmapped_err", er, 1);
    $display("reset and map test done");
    lf = nx(lf);
    wr(12'h004, lf & 32'hff);
    wr(12'h008, (lf >> 8) & 32'hff);
    wr(12'h000, 32'hed);
    regs;
    chk("pwm_on", pwm, 1);
    chk("pwm_duty", duty, {e_lo[7:0], 2'h2});
    for (k = 0; k < 4; k++) begin
      ta <= k[1:0];
      repeat (3) @(posedge clk);
      // unit two moves to timers three/four under 01 and 11 only
      chk("use_fourth", u4, k[0]);
    end
    $display("register and pwm test done");
    for (m = 4; m < 8; m++) begin
      ta <= m[1:0];
      wr(12'h000, 0);
      wr(12'h000, m);
      wr(12'h00c, 1);
      n = (m == 6) ? 4 : (m == 7) ? 16 : 2;
      for (k = 1; k <= n; k++) begin
        lf = nx(lf);
        ld_t(lf[15:0]);
        pulse;
        if (k == n - 1 && m > 5) begin
          apb(0, 12'h00c, 32'h0);
          chk("prescale_hold", r[0], 0);
        end
      end
      x = m[0] ? lf[15:0] ^ 16'hffff : lf[15:0];
      e_lo = x[7:0]; e_hi = x[15:8]; e_fl = 1;
      chk("use_third", u3, m[0]);
      chk("far_third", u33, m != 4);
      regs;
    end
    wr(12'h000, 0); wr(12'h000, 6); wr(12'h00c, 1);
    repeat (2) pulse;
    wr(12'h000, 0); wr(12'h000, 6); wr(12'h00c, 1);
    repeat (3) pulse;
    apb(0, 12'h00c, 32'h0);
    chk("prescale_cleared", r[0], 0);
    wr(12'h000, 5); wr(12'h00c, 1);
    pio <= 1; pdat <= 1;
    repeat (5) @(posedge clk);
    apb(0, 12'h00c, 32'h0);
    chk("port_write_capture", r[0], 1);
    pio <= 0; pdat <= 0; ta <= 0;
    $display("capture test done");
    for (k = 0; k < 6; k++) begin
      // the last pass moves both units to timer three for a second special event
      ta <= (k == 5) ? 2'h3 : 2'h0;
      lf = nx(lf);
      v = lf[15:0] | 16'h0100;
      ld_t(v ^ 16'h0001);
      wr(12'h000, 0);
      chk("out_off", cmp, 0);
      wr(12'h004, v[7:0]); wr(12'h008, v[15:8]);
      wr(12'h000, cm[k]); wr(12'h00c, 1);
      chk("out_entry", cmp, k == 2);
      ld_t((k == 5) ? v ^ 16'hffff : v);
      @(posedge clk);
      // special pulses stand for one cycle only, so look half a cycle in
      @(negedge clk);
      chk("special_first", rf, k == 4);
      chk("special_third", rt, k == 5);
      chk("conversion", sc, k > 3);
      chk("far_special", {rf3, rt3, sc3}, 0);
      repeat (3) @(posedge clk);
      chk("out_match", cmp, k < 2);
      chk("match_flag", flg, 1);
      chk("far_out", c3, k < 2);
      chk("far_flag", f3, 1);
      if (k == 4) chk("timer_reset", t1, 0);
    end
    $display("compare test done");
    print_verdict;
  end
endmodule
